// ### sqoc_consts.svh
`ifndef SQOC_CONSTS_SVH
`define SQOC_CONSTS_SVH

// Register byte addresses on the serial port
`define ADDR_SYNC_QUALIFY     15'h0210
`define ADDR_OVERRANGE_LEVEL  15'h0211
`define ADDR_OVERRANGE_CONFIG 15'h0213
`define ADDR_STARTUP_STATE    15'h0270
`define ADDR_POWER_PROFILE_B  15'h029a

// Reset values
`define RST_SYNC_QUALIFY      8'h03
`define RST_OVERRANGE_LEVEL   8'hf2
`define RST_OVERRANGE_CONFIG  8'h07
`define RST_POWER_PROFILE_B   8'h0f

// Field positions
`define SYNC_QUALIFY_MSB      4
`define OVR_ENABLE_BIT        3
`define OVR_EXP_MSB           2
`define INIT_DONE_BIT         0

// Serial frame: one read flag, 15 address bits, 8 data bits
`define SPI_HDR_BITS          5'h10
`define SPI_FRAME_BITS        5'h18

// Timing: clock rate, sample-rate divider, link clock is half the sample rate
`define SYS_CLK_MHZ           125
`define SAMPLE_DIV            4'h2
`define OVR_BASE_CYCLES       10'h004

// Internal initialisation time and its cycle count, rounded up
`define INIT_TIME_NS          1000
`define INIT_CYCLES           ((`INIT_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// ### sqoc_pkg.sv
package sqoc_pkg;
  typedef enum logic [0:0] {INIT_RUN, INIT_FINISHED} init_state_t;
endpackage

// ### overrange_detect.sv
`timescale 1ns/10ps
`default_nettype none
`include "sqoc_consts.svh"

module overrange_detect (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        sample_en,
  input  wire logic [11:0] sample,
  input  wire logic [7:0]  level,
  input  wire logic [2:0]  exponent,
  input  wire logic        enable,
  output logic             flag
);
  logic [7:0] top;
  logic [8:0] mag;
  logic       exceed;
  logic [9:0] hold_q;
  logic       flag_q;

  // Magnitude of the upper byte, scaled so full scale is 256
  assign top    = sample[11:4];
  assign mag    = top[7] ? 9'h000 - {top[7], top} : {1'b0, top};
  assign exceed = ({mag[7:0], 1'b0} >= {1'b0, level}) || mag[8];

  // Stretch counter restarts on every new exceedance
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 10'h000;
    end else if (sample_en) begin
      if (exceed) begin
        hold_q <= `OVR_BASE_CYCLES << exponent;
      end else if (hold_q != 10'h000) begin
        hold_q <= hold_q - 10'h001;
      end
    end
  end

  // Output gated by the enable bit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= enable && (exceed && sample_en || hold_q != 10'h000);
    end
  end

  assign flag = flag_q;

  property p_ovr_gate;
    @(posedge sys_clk) disable iff (!rst_b) !enable |=> !flag_q;
  endproperty
  a_ovr_gate: assert property (p_ovr_gate) else $error("flag high while disabled");

  property p_ovr_set;
    @(posedge sys_clk) disable iff (!rst_b) enable && sample_en && exceed |=> flag_q;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("flag missed exceedance");

  property p_ovr_load;
    @(posedge sys_clk) disable iff (!rst_b)
      sample_en && exceed |=> hold_q == (10'h004 << $past(exponent));
  endproperty
  a_ovr_load: assert property (p_ovr_load) else $error("stretch length wrong");

  property p_ovr_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      enable && hold_q > 10'h001 && !$rose(enable) |=> flag_q;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("flag dropped early");
endmodule
`default_nettype wire

// ### sync_qualify_overrange_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "sqoc_consts.svh"

module sync_qualify_overrange_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_b,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  input  wire logic        sync_b,
  input  wire logic        serial_link_enable,
  input  wire logic [11:0] sample_a,
  input  wire logic [11:0] sample_b,
  input  wire logic [11:0] sample_c,
  input  wire logic [11:0] sample_d,
  output logic             sync_request,
  output logic             overrange_flag_a,
  output logic             overrange_flag_b,
  output logic             overrange_flag_c,
  output logic             overrange_flag_d,
  output logic [7:0]       power_profile_b_value,
  output logic             init_done
);
  logic [7:0]            sync_qualify_q;
  logic [7:0]            overrange_level_q;
  logic [7:0]            overrange_config_q;
  logic [7:0]            power_profile_b_q;
  sqoc_pkg::init_state_t init_state_q;
  logic [7:0]            init_cnt_q;
  logic [3:0]            div_q;
  logic                  sample_en;
  logic                  link_phase_q;
  logic                  link_en;
  logic [5:0]            low_cnt_q;
  logic                  sync_request_q;
  logic                  sclk_q;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic [4:0]            bit_cnt_q;
  logic [23:0]           shift_in_q;
  logic [7:0]            shift_out_q;
  logic                  sdo_q;
  logic                  rd_flag_q;
  logic [23:0]           shift_in_d;
  logic                  wr_stb;
  logic [14:0]           wr_addr;
  logic [7:0]            rd_data;

  // Sample-rate and link-rate enables from one divider
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q        <= 4'h0;
      link_phase_q <= 1'b0;
    end else if (div_q == `SAMPLE_DIV - 4'h1) begin
      div_q        <= 4'h0;
      link_phase_q <= ~link_phase_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign sample_en = (div_q == `SAMPLE_DIV - 4'h1);
  assign link_en   = sample_en && link_phase_q;

  // Consecutive-low counter on the link clock, saturating
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= 6'h00;
    end else if (link_en) begin
      if (sync_b) begin
        low_cnt_q <= 6'h00;
      end else if (low_cnt_q != 6'h3f) begin
        low_cnt_q <= low_cnt_q + 6'h01;
      end
    end
  end

  // Request only once the low run passes the threshold; shorter runs do nothing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_request_q <= 1'b0;
    end else if (link_en) begin
      sync_request_q <= !sync_b &&
        ({1'b0, low_cnt_q} + 7'h01 >= {2'b00, sync_qualify_q[`SYNC_QUALIFY_MSB:0]} + 7'h01);
    end
  end

  assign sync_request = sync_request_q;

  // Internal initialisation sequence
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_state_q <= sqoc_pkg::INIT_RUN;
      init_cnt_q   <= 8'h00;
    end else begin
      case (init_state_q)
        sqoc_pkg::INIT_RUN: begin
          if (init_cnt_q == 8'(`INIT_CYCLES - 1)) begin
            init_state_q <= sqoc_pkg::INIT_FINISHED;
          end else begin
            init_cnt_q <= init_cnt_q + 8'h01;
          end
        end
        default: begin
          init_state_q <= sqoc_pkg::INIT_FINISHED;
        end
      endcase
    end
  end

  assign init_done = (init_state_q == sqoc_pkg::INIT_FINISHED);

  // Serial port: sclk sampled as a synchronous input
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk;
    end
  end

  assign sclk_rise  = spi_sclk && !sclk_q && !spi_cs_b;
  assign sclk_fall  = !spi_sclk && sclk_q && !spi_cs_b;
  assign shift_in_d = {shift_in_q[22:0], spi_sdi};
  assign wr_stb     = sclk_rise && bit_cnt_q == `SPI_FRAME_BITS - 5'h01 && !shift_in_q[22];
  assign wr_addr    = shift_in_q[21:7];

  // Bit counter and input shifter
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_q  <= 5'h00;
      shift_in_q <= 24'h000000;
    end else if (spi_cs_b) begin
      bit_cnt_q <= 5'h00;
    end else if (sclk_rise && bit_cnt_q != `SPI_FRAME_BITS) begin
      bit_cnt_q  <= bit_cnt_q + 5'h01;
      shift_in_q <= shift_in_d;
    end
  end

  // Read data mux; unmapped addresses and the upper startup-state bits read zero, other registers read back all 8 stored bits
  always_comb begin
    rd_data = 8'h00;
    case (shift_in_d[14:0])
      `ADDR_SYNC_QUALIFY:     rd_data = sync_qualify_q;
      `ADDR_OVERRANGE_LEVEL:  rd_data = overrange_level_q;
      `ADDR_OVERRANGE_CONFIG: rd_data = overrange_config_q;
      `ADDR_STARTUP_STATE:    rd_data = {7'h00, init_done};
      `ADDR_POWER_PROFILE_B:  rd_data = power_profile_b_q;
      default:                rd_data = 8'h00;
    endcase
  end

  // Read shifter loaded after the header, shifted out on falling edges
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_out_q <= 8'h00;
      sdo_q       <= 1'b0;
      rd_flag_q   <= 1'b0;
    end else if (sclk_rise && bit_cnt_q == `SPI_HDR_BITS - 5'h01) begin
      shift_out_q <= rd_data;
      rd_flag_q   <= shift_in_d[15];
    end else if (sclk_fall && bit_cnt_q >= `SPI_HDR_BITS && bit_cnt_q < `SPI_FRAME_BITS) begin
      sdo_q       <= shift_out_q[7];
      shift_out_q <= {shift_out_q[6:0], 1'b0};
    end
  end

  assign spi_sdo    = sdo_q;
  assign spi_sdo_oe = !spi_cs_b && rd_flag_q && bit_cnt_q >= `SPI_HDR_BITS;   // Flag kept, the shifter moves on

  // Writable registers; host keeps link disabled while changing qualify count
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_qualify_q     <= `RST_SYNC_QUALIFY;
      overrange_level_q  <= `RST_OVERRANGE_LEVEL;
      overrange_config_q <= `RST_OVERRANGE_CONFIG;
      power_profile_b_q  <= `RST_POWER_PROFILE_B;
    end else if (wr_stb) begin
      case (wr_addr)
        `ADDR_SYNC_QUALIFY:     sync_qualify_q     <= shift_in_d[7:0];
        `ADDR_OVERRANGE_LEVEL:  overrange_level_q  <= shift_in_d[7:0];
        `ADDR_OVERRANGE_CONFIG: overrange_config_q <= shift_in_d[7:0];
        `ADDR_POWER_PROFILE_B:  power_profile_b_q  <= shift_in_d[7:0];
        default: begin
        end
      endcase
    end
  end

  assign power_profile_b_value = power_profile_b_q;

  // Four identical detectors
  overrange_detect u_ovr_a (.sys_clk(sys_clk), .rst_b(rst_b), .sample_en(sample_en), .sample(sample_a),
    .level(overrange_level_q), .exponent(overrange_config_q[`OVR_EXP_MSB:0]),
    .enable(overrange_config_q[`OVR_ENABLE_BIT]), .flag(overrange_flag_a));
  overrange_detect u_ovr_b (.sys_clk(sys_clk), .rst_b(rst_b), .sample_en(sample_en), .sample(sample_b),
    .level(overrange_level_q), .exponent(overrange_config_q[`OVR_EXP_MSB:0]),
    .enable(overrange_config_q[`OVR_ENABLE_BIT]), .flag(overrange_flag_b));
  overrange_detect u_ovr_c (.sys_clk(sys_clk), .rst_b(rst_b), .sample_en(sample_en), .sample(sample_c),
    .level(overrange_level_q), .exponent(overrange_config_q[`OVR_EXP_MSB:0]),
    .enable(overrange_config_q[`OVR_ENABLE_BIT]), .flag(overrange_flag_c));
  overrange_detect u_ovr_d (.sys_clk(sys_clk), .rst_b(rst_b), .sample_en(sample_en), .sample(sample_d),
    .level(overrange_level_q), .exponent(overrange_config_q[`OVR_EXP_MSB:0]),
    .enable(overrange_config_q[`OVR_ENABLE_BIT]), .flag(overrange_flag_d));

  property p_sync_qualify;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(sync_request_q) |-> low_cnt_q == {1'b0, sync_qualify_q[4:0]} + 6'h01;
  endproperty
  a_sync_qualify: assert property (p_sync_qualify) else $error("sync request at wrong count");

  property p_sync_short;
    @(posedge sys_clk) disable iff (!rst_b)
      sync_request_q |-> low_cnt_q > {1'b0, sync_qualify_q[4:0]};
  endproperty
  a_sync_short: assert property (p_sync_short) else $error("short low pulse acted on");

  property p_sync_link_rate;
    @(posedge sys_clk) disable iff (!rst_b) !link_en |=> $stable(low_cnt_q);
  endproperty
  a_sync_link_rate: assert property (p_sync_link_rate) else $error("sync sampled off link clock");

  property p_init_sticky;
    @(posedge sys_clk) disable iff (!rst_b) init_done |=> init_done;
  endproperty
  a_init_sticky: assert property (p_init_sticky) else $error("init done dropped");

  property p_init_time;
    @(posedge sys_clk) disable iff (!rst_b)
      !init_done && init_cnt_q == 8'(`INIT_CYCLES - 1) |=> init_done;
  endproperty
  a_init_time: assert property (p_init_time) else $error("init done late");

  property p_power_write;
    @(posedge sys_clk) disable iff (!rst_b)
      wr_stb && wr_addr == `ADDR_POWER_PROFILE_B |=> power_profile_b_value == $past(shift_in_d[7:0]);
  endproperty
  a_power_write: assert property (p_power_write) else $error("power profile not written");
endmodule
`default_nettype wire

// ### spi_link_host.sv
`timescale 1ns/10ps
`default_nettype none

module spi_link_host (
  input  wire logic sys_clk,
  input  wire logic init_done,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe,
  output logic      spi_sclk,
  output logic      spi_cs_b,
  output logic      spi_sdi,
  output logic      sync_b,
  output logic      serial_link_enable
);
  // Idle bus, receiver not asking for sync, link off
  initial begin
    spi_sclk           = 1'b0;
    spi_cs_b           = 1'b1;
    spi_sdi            = 1'b0;
    sync_b             = 1'b1;
    serial_link_enable = 1'b0;
  end

  // Link enable level; qualify and profile writes happen only while low
  task automatic set_link(input logic en);
    @(negedge sys_clk);
    serial_link_enable = en;
  endtask

  // Sync line level from the receiver, error reporting left off
  task automatic set_sync(input logic lvl);
    sync_b = lvl;
  endtask

  // One frame: read flag, address, data, sclk half periods of 4 clocks
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                      output logic [7:0] rd_q);
    logic [23:0] frame;
    frame = {rd, addr, wd};
    rd_q  = 8'h00;
    wait (init_done === 1'b1);
    @(negedge sys_clk);
    spi_cs_b = 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(negedge sys_clk);
      spi_sclk = 1'b0;
      spi_sdi  = frame[23-i];
      repeat (4) @(negedge sys_clk);
      if (i >= 16) rd_q = {rd_q[6:0], spi_sdo & spi_sdo_oe};
      spi_sclk = 1'b1;
      repeat (3) @(negedge sys_clk);
    end
    repeat (4) @(negedge sys_clk);
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    // Released data line does not keep its last level
    spi_sdi  = ~spi_sdi;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule

`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sqoc_consts.svh"

module tb;
  logic        sys_clk, rst_b, spi_sclk, spi_cs_b, spi_sdi, spi_sdo, spi_sdo_oe;
  logic        sync_b, serial_link_enable, sync_request, init_done;
  logic        overrange_flag_a, overrange_flag_b, overrange_flag_c, overrange_flag_d;
  logic [11:0] sample_a, sample_b, sample_c, sample_d;
  logic [7:0]  power_profile_b_value, rd;
  logic [3:0]  flags;
  int          mismatches, checked, cycles;
  logic [14:0] addr_tab [6] = '{`ADDR_SYNC_QUALIFY, `ADDR_OVERRANGE_LEVEL, `ADDR_OVERRANGE_CONFIG,
                                `ADDR_STARTUP_STATE, `ADDR_POWER_PROFILE_B, 15'h0212};
  logic [7:0]  rst_tab [6]  = '{8'h03, 8'hf2, 8'h07, 8'h01, 8'h0f, 8'h00};

  assign flags = {overrange_flag_a, overrange_flag_b, overrange_flag_c, overrange_flag_d};

  sync_qualify_overrange_ctrl i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sync_b(sync_b),
    .serial_link_enable(serial_link_enable), .sample_a(sample_a), .sample_b(sample_b),
    .sample_c(sample_c), .sample_d(sample_d), .sync_request(sync_request),
    .overrange_flag_a(overrange_flag_a), .overrange_flag_b(overrange_flag_b),
    .overrange_flag_c(overrange_flag_c), .overrange_flag_d(overrange_flag_d),
    .power_profile_b_value(power_profile_b_value), .init_done(init_done));

  spi_link_host i_host (
    .sys_clk(sys_clk), .init_done(init_done), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_sdi(spi_sdi), .sync_b(sync_b),
    .serial_link_enable(serial_link_enable));

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Cut a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [14:0] addr, input logic [7:0] d);
    i_host.xfer(1'b0, addr, d, rd);
  endtask

  task automatic reg_rd(input logic [14:0] addr, input logic [7:0] exp);
    i_host.xfer(1'b1, addr, 8'h00, rd);
    check("register", exp, rd);
  endtask

  // Low sync for n clocks, watching for a request from the first clock until 16 clocks after release
  task automatic sync_try(input int n, input logic exp);
    logic seen;
    seen = 1'b0;
    @(negedge sys_clk);
    i_host.set_sync(1'b0);
    for (int i = 0; i < n + 16; i++) begin
      if (i == n) i_host.set_sync(1'b1);
      @(negedge sys_clk);
      seen |= (sync_request === 1'b1);
    end
    check("sync request seen", {7'h00, exp}, {7'h00, seen});
    check("sync request dropped", 8'h00, {7'h00, sync_request});
  endtask

  // Exceeding sample on the channels in m, again after gap clocks if gap is nonzero;
  // count the clocks in which exactly those flags stand
  task automatic ovr_try(input logic [3:0] m, input logic [11:0] s, input int gap, input int lo, input int hi);
    int n;
    n = 0;
    for (int i = 0; i < 48; i++) begin
      if (i == 0 || (gap > 0 && i == gap)) begin
        sample_a = m[3] ? s : 12'h000;
        sample_b = m[2] ? s : 12'h000;
        sample_c = m[1] ? s : 12'h000;
        sample_d = m[0] ? s : 12'h000;
      end else if (i == 2 || (gap > 0 && i == gap + 2)) begin
        {sample_a, sample_b, sample_c, sample_d} = '0;
      end
      @(negedge sys_clk);
      if (flags === m) n++;
      else if (flags !== 4'h0) n = 100;
    end
    checked++;
    if (n < lo || n > hi) begin
      mismatches++;
      $display("MISMATCH overrange cycles expected %0d to %0d seen %0d", lo, hi, n);
    end
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    {sample_a, sample_b, sample_c, sample_d} = '0;
    repeat (5) @(negedge sys_clk);
    check("profile in reset", `RST_POWER_PROFILE_B, power_profile_b_value);
    rst_b = 1'b1;
    repeat (`INIT_CYCLES - 5) @(negedge sys_clk);
    check("init early", 8'h00, {7'h00, init_done});
    repeat (10) @(negedge sys_clk);
    check("init late", 8'h01, {7'h00, init_done});
    for (int i = 0; i < 6; i++) reg_rd(addr_tab[i], rst_tab[i]);
    reg_wr(15'h0212, 8'h55);
    reg_rd(15'h0212, 8'h00);
    reg_wr(`ADDR_STARTUP_STATE, 8'hfe);
    reg_rd(`ADDR_STARTUP_STATE, 8'h01);
    // Power profile, link held off around the change
    reg_wr(`ADDR_POWER_PROFILE_B, 8'h06);
    check("profile port", 8'h06, power_profile_b_value);
    reg_rd(`ADDR_POWER_PROFILE_B, 8'h06);
    reg_wr(`ADDR_POWER_PROFILE_B, 8'h0f);
    check("profile port", 8'h0f, power_profile_b_value);
    // Sync qualify at reset value 3, then 0
    i_host.set_link(1'b1);
    sync_try(12, 1'b0);
    sync_try(16, 1'b1);
    i_host.set_link(1'b0);
    reg_wr(`ADDR_SYNC_QUALIFY, 8'h00);
    i_host.set_link(1'b1);
    sync_try(4, 1'b1);
    i_host.set_link(1'b0);
    // Over-range: gated off, threshold boundaries, per channel, restart, stretch lengths
    reg_wr(`ADDR_OVERRANGE_CONFIG, 8'h00);
    ovr_try(4'hf, 12'h7ff, 0, 0, 0);
    reg_wr(`ADDR_OVERRANGE_CONFIG, 8'h08);
    ovr_try(4'hf, 12'h790, 0, 6, 12);
    ovr_try(4'hf, 12'h780, 0, 0, 0);
    ovr_try(4'hf, 12'h870, 0, 6, 12);
    ovr_try(4'hf, 12'h880, 0, 0, 0);
    ovr_try(4'h8, 12'h7ff, 0, 6, 12);
    ovr_try(4'h4, 12'h800, 0, 6, 12);
    ovr_try(4'h2, 12'h7ff, 0, 6, 12);
    ovr_try(4'h1, 12'h800, 0, 6, 12);
    ovr_try(4'hf, 12'h790, 8, 15, 20);
    reg_wr(`ADDR_OVERRANGE_CONFIG, 8'h09);
    ovr_try(4'hf, 12'h790, 0, 14, 20);
    reg_wr(`ADDR_OVERRANGE_LEVEL, 8'h80);
    ovr_try(4'hf, 12'h400, 0, 14, 20);
    ovr_try(4'hf, 12'h3f0, 0, 0, 0);
    report_and_stop();
  end
endmodule

`default_nettype wire
